// >>> rtl/sdb_pkg.sv
// Package for the slope delta bit path: widths, history patterns and reset values.
// Assumes a single 250 MHz system clock; the codec clock arrives as a sampled level.
package sdb_pkg;

   // History register shape
   localparam int unsigned HIST_W = 3;

   // Patterns that mark coincidence
   localparam logic [HIST_W-1:0] HIST_ALL_ONES  = 3'h7;
   localparam logic [HIST_W-1:0] HIST_ALL_ZEROS = 3'h0;

   // Reset and clear values
   localparam logic [HIST_W-1:0] HIST_RST    = 3'h0;
   localparam logic              DOUT_RST    = 1'h0;
   localparam logic              LVL_RST     = 1'h0;
   localparam logic              STB_RST     = 1'h0;
   localparam logic              COINC_N_RST = 1'h0;

   // Open-drain coincidence pin only ever pulls low
   localparam logic OD_PULL_LVL = 1'h0;

   // Encode/decode select levels
   localparam logic MODE_ENCODE = 1'h1;

   // Coincidence test, used by the datapath and its checks
   function automatic logic sdb_is_coinc(input logic [HIST_W-1:0] h);
      return (h == HIST_ALL_ONES) || (h == HIST_ALL_ZEROS);
   endfunction

endpackage

// >>> rtl/sdb_fall_det.sv
// Falling edge detector for a level sampled on the system clock.
// Assumes the level is already synchronous to ref_clk_i.
`timescale 1ns/100ps
`default_nettype none

module sdb_fall_det (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   // Level in, pulse out
   input  wire logic lvl_i,
   output logic      fall_o
);
   import sdb_pkg::*;

   typedef struct packed {
      logic prev;
   } sdb_fd_state_t;

   sdb_fd_state_t st;
   sdb_fd_state_t next_st;

   // Remember last level
   always_comb begin
      next_st      = st;
      next_st.prev = lvl_i;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st.prev <= LVL_RST;
      end else begin
         st <= next_st;
      end
   end

   // High then low means a falling edge; one cycle wide
   assign fall_o = st.prev & ~lvl_i;

endmodule

`default_nettype wire

// >>> rtl/sdb_bit_path.sv
// Digital bit path of a slope delta codec: bit select, 3-bit history,
// serial output, coincidence and integrating-current polarity.
// Assumes all inputs synchronous to ref_clk_i and a codec clock far slower.
`timescale 1ns/100ps
`default_nettype none

module sdb_bit_path (
   // System clock and resets
   input  wire logic                      ref_clk_i,
   input  wire logic                      rstn_i,
   input  wire logic                      sync_clr_i,
   // Codec clock and mode
   input  wire logic                      codec_clk_i,
   input  wire logic                      enc_sel_i,
   // Bit sources
   input  wire logic                      cmp_fb_gt_in_i,
   input  wire logic                      data_in_i,
   // Serial output and analog steering
   output logic                           dout_o,
   output logic                           pol_into_o,
   output logic                           shift_stb_o,
   output logic [sdb_pkg::HIST_W-1:0]     hist_o,
   // Coincidence, open-drain pin plus level view
   output logic                           coinc_n_o,
   output logic                           coinc_out_o,
   output logic                           coinc_oe_o
);
   import sdb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [HIST_W-1:0] hist;
      logic              dout;
      logic              pol_into;
      logic              coinc_n;
      logic              stb;
   } sdb_state_t;

   sdb_state_t st;
   sdb_state_t next_st;
   logic       codec_fall;
   logic       sel_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Codec clock edge

   // Edge found on the sampled codec clock; glitches shorter than a
   // system clock are not filtered, the pin is assumed clean.
   sdb_fall_det u_fall (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .lvl_i     (codec_clk_i),
      .fall_o    (codec_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bit selection

   // loopback toggle stage
   // Decode inverts the data input so a loopback forms a toggle stage.
   always_comb begin
      if (enc_sel_i == MODE_ENCODE) begin
         sel_bit = cmp_fb_gt_in_i;
      end else begin
         sel_bit = ~data_in_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st     = st;
      next_st.stb = STB_RST;
      if (sync_clr_i) begin
         next_st.hist     = HIST_RST;
         next_st.dout     = DOUT_RST;
         next_st.pol_into = ~DOUT_RST;
         next_st.coinc_n  = ~sdb_is_coinc(HIST_RST);
      end else if (codec_fall) begin
         next_st.hist = {st.hist[HIST_W-2:0], sel_bit};
         next_st.dout = sel_bit;
         // polarity from bit
         // Current flows in exactly when the presented bit is low.
         next_st.pol_into = ~sel_bit;
         next_st.coinc_n  = ~sdb_is_coinc({st.hist[HIST_W-2:0], sel_bit});
         next_st.stb      = ~STB_RST;
      end
   end

   // Async reset to constants; the coincidence level matches the cleared history
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st.hist     <= HIST_RST;
         st.dout     <= DOUT_RST;
         st.pol_into <= ~DOUT_RST;
         st.coinc_n  <= COINC_N_RST;
         st.stb      <= STB_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // All from flops but coinc_out_o, a constant; the open-drain pin pulls low while coincidence holds
   assign dout_o      = st.dout;
   assign pol_into_o  = st.pol_into;
   assign shift_stb_o = st.stb;
   assign hist_o      = st.hist;
   assign coinc_n_o   = st.coinc_n;
   assign coinc_out_o = OD_PULL_LVL;
   assign coinc_oe_o  = ~st.coinc_n;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_coinc_level : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      coinc_n_o == !sdb_is_coinc(hist_o) && coinc_oe_o == !coinc_n_o)
      else $error("coincidence output disagrees with history");

   chk_out_on_fall : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      !codec_fall && !sync_clr_i |=> $stable(dout_o))
      else $error("serial output changed without codec falling edge");

   chk_hist_shift : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && !sync_clr_i |=> hist_o == {$past(hist_o[1:0]), dout_o})
      else $error("history did not shift in output bit");

   chk_one_bit : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      shift_stb_o |=> !shift_stb_o)
      else $error("two bits taken in one codec clock period");

   chk_stb_cause : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && !sync_clr_i |=> shift_stb_o)
      else $error("falling edge did not produce a bit strobe");

   chk_enc_bit : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && !sync_clr_i && enc_sel_i |=> dout_o == $past(cmp_fb_gt_in_i))
      else $error("encode output does not follow comparator");

   chk_dec_invert : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && !sync_clr_i && !enc_sel_i |=> dout_o == !$past(data_in_i))
      else $error("decode output is not the inverse of data input");

   chk_loop_toggle : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && !sync_clr_i && !enc_sel_i && data_in_i == dout_o
      |=> dout_o != $past(dout_o))
      else $error("looped back output failed to toggle");

   chk_pol_follow : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      pol_into_o == !dout_o)
      else $error("integrating polarity not opposite to output bit");

   chk_sync_clear : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      sync_clr_i |=> hist_o == HIST_RST && dout_o == DOUT_RST && !coinc_n_o)
      else $error("synchronous clear did not set defined state");

   chk_hist_hold : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      !codec_fall && !sync_clr_i |=> $stable(hist_o))
      else $error("history moved without codec falling edge");

   chk_newest_out : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      hist_o[0] == dout_o)
      else $error("newest history bit differs from output bit");

   // A fall that meets the clear must leave no strobe and a cleared history
   chk_clear_wins : assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && sync_clr_i |=> !shift_stb_o && hist_o == HIST_RST)
      else $error("bit taken during synchronous clear");

   // Main scenarios
   cov_encode_coinc : cover property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      enc_sel_i && shift_stb_o && !coinc_n_o);

   cov_decode_shift : cover property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      !enc_sel_i && shift_stb_o && coinc_n_o);

   cov_idle_toggle : cover property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      shift_stb_o && hist_o == 3'h5);

   cov_clear_on_fall : cover property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      codec_fall && sync_clr_i);

endmodule

`default_nettype wire

// >>> tb/sdb_far_end.sv
// Far-end model: host codec clock and the serial channel of the bit path.
// Assumes one system clock; the codec clock stands low while run_i is low.
`timescale 1ns/100ps
`default_nettype none

module sdb_far_end (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   // Host controls
   input  wire logic run_i,
   input  wire logic loop_i,
   input  wire logic pat_i,
   // Channel
   input  wire logic dout_i,
   output logic      codec_clk_o,
   output logic      data_in_o
);
   logic [2:0] cnt;

   ////////////////////////////////////////
   // one bit per period
   // High 2 cycles, low 3, well above the minimum phase widths
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 3'h0;
      end else begin
         cnt <= (!run_i || cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      end
   end
   assign codec_clk_o = run_i && (cnt < 3'h2);

   assign data_in_o = loop_i ? dout_i : pat_i;
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the slope delta bit path, directed scenarios.
// Assumes the far-end model supplies the codec clock and serial data.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import sdb_pkg::*;
   logic              ref_clk = 1'h0;
   logic              rstn = 1'h0;
   logic              clr = 1'h0;
   logic              enc = 1'h0;
   logic              cmp = 1'h0;
   logic              run = 1'h0;
   logic              loop = 1'h0;
   logic              pat = 1'h0;
   logic              cclk, din, dout, pol, stb, c_n, c_out, c_oe;
   logic [HIST_W-1:0] hist;
   logic [HIST_W-1:0] exp_h;
   int                num_errors = 0;
   int                checks = 0;

   always #2 ref_clk = ~ref_clk;

   sdb_bit_path dut_u (.ref_clk_i(ref_clk), .rstn_i(rstn), .sync_clr_i(clr), .codec_clk_i(cclk),
      .enc_sel_i(enc), .cmp_fb_gt_in_i(cmp), .data_in_i(din), .dout_o(dout), .pol_into_o(pol),
      .shift_stb_o(stb), .hist_o(hist), .coinc_n_o(c_n), .coinc_out_o(c_out), .coinc_oe_o(c_oe));
   sdb_far_end far_u (.ref_clk_i(ref_clk), .rstn_i(rstn), .run_i(run), .loop_i(loop),
      .pat_i(pat), .dout_i(dout), .codec_clk_o(cclk), .data_in_o(din));

   ////////////////////////////////////////
   // Compare and report
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   // Outputs against the tracked history
   task automatic chk_state(input string what);
      logic c;
      c = (exp_h == HIST_ALL_ONES) || (exp_h == HIST_ALL_ZEROS);
      chk({3'h0, dout, pol, hist}, {3'h0, exp_h[0], ~exp_h[0], exp_h}, what);
      chk({5'h0, c_n, c_oe, c_out}, {5'h0, ~c, c, OD_PULL_LVL}, what);
   endtask

   // One codec bit: set sources, wait for the shift, then one quiet cycle
   task automatic step(input logic e, input logic cm, input logic dn, input logic lp,
                       input string what);
      logic b;
      int   n;
      b = e ? cm : (lp ? exp_h[0] : dn);
      b = e ? b : ~b;
      n = 0;
      enc = e;
      cmp = cm;
      pat = dn;
      loop = lp;
      @(posedge ref_clk);
      #1;
      while (stb !== 1'h1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({7'h0, stb}, 8'h1, "strobe");
      exp_h = {exp_h[1:0], b};
      @(posedge ref_clk);
      #1;
      chk({7'h0, stb}, 8'h0, "strobe width");
      chk_state(what);
   endtask

   ////////////////////////////////////////
   // Scenarios
   // Reset values, then comparator bits
   task automatic t_encode();
      logic [7:0] v;
      exp_h = HIST_RST;
      chk_state("reset");
      v = 8'h17;
      for (int i = 0; i < 8; i++) step(1'h1, v[i], v[i], 1'h0, "encode");
      $display("test encode done");
   endtask

   // Forced pattern on the data input
   task automatic t_decode();
      logic [7:0] v;
      v = 8'hc8;
      for (int i = 0; i < 8; i++) step(1'h0, v[i], v[i], 1'h0, "decode");
      $display("test decode done");
   endtask

   // Output looped back to the data input
   task automatic t_loop();
      for (int i = 0; i < 6; i++) step(1'h0, 1'h0, 1'h0, 1'h1, "loop");
      $display("test loop done");
   endtask

   // Clear between codec falls, then a normal bit
   task automatic t_clear();
      clr = 1'h1;
      @(posedge ref_clk);
      #1;
      clr = 1'h0;
      @(posedge ref_clk);
      #1;
      exp_h = HIST_RST;
      chk_state("clear");
      step(1'h1, 1'h1, 1'h1, 1'h0, "after clear");
      $display("test clear done");
   endtask

   // Clear raised so that it meets a codec fall on the same edge
   task automatic t_clear_on_fall();
      int n;
      n = 0;
      enc = 1'h1;
      cmp = 1'h1;
      loop = 1'h0;
      while (cclk !== 1'h1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (cclk !== 1'h0 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      // The codec clock has just gone low and the detector output is high; the clear meets it at the next edge and no bit is taken
      clr = 1'h1;
      @(posedge ref_clk);
      #1;
      clr = 1'h0;
      exp_h = HIST_RST;
      chk({7'h0, stb}, 8'h0, "strobe under clear");
      chk_state("clear over fall");
      step(1'h1, 1'h1, 1'h1, 1'h0, "after clear over fall");
      $display("test clear on fall done");
   endtask

   // Reset in mid-run; the far end is reset too and holds the codec clock high
   task automatic t_reset();
      rstn = 1'h0;
      @(posedge ref_clk);
      #1;
      exp_h = HIST_RST;
      chk({7'h0, stb}, 8'h0, "strobe in reset");
      chk_state("in reset");
      @(posedge ref_clk);
      #1;
      rstn = 1'h1;
      @(posedge ref_clk);
      #1;
      chk_state("after reset");
      step(1'h1, 1'h0, 1'h0, 1'h0, "after reset");
      $display("test reset done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      rstn = 1'h1;
      run = 1'h1;
      t_encode();
      t_decode();
      t_loop();
      t_clear();
      t_clear_on_fall();
      t_reset();
      summarize();
   end

   // Watchdog, far beyond the 140 or so cycles the run needs
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
endmodule

`default_nettype wire
